// File: common/retimer_cfg_pkg.sv
// Constants shared by the retimer channel configuration block.
// Assumes a 250 MHz register clock and a Wishbone byte address of 10 bits.
package retimer_cfg_pkg;
  localparam int NUM_CH = 4;
  localparam int ADR_W  = 10;
  // Address layout: global block bit, broadcast bit, channel, register index.
  localparam int ADR_GLOBAL = 9;
  localparam int ADR_BCAST  = 8;
  localparam int ADR_CH_LSB = 6;
  localparam int ADR_RG_LSB = 2;
  // Channel register indices.
  localparam logic [3:0] RG_EQ_CTRL  = 4'h0;
  localparam logic [3:0] RG_BOOST    = 4'h1;
  localparam logic [3:0] RG_DFE      = 4'h2;
  localparam logic [3:0] RG_CDR      = 4'h3;
  localparam logic [3:0] RG_RATE0    = 4'h4;
  localparam logic [3:0] RG_RATE1    = 4'h5;
  localparam logic [3:0] RG_TXFIR    = 4'h6;
  localparam logic [3:0] RG_GEN      = 4'h7;
  localparam logic [3:0] RG_CHK      = 4'h8;
  localparam logic [3:0] RG_CHK_BITS = 4'h9;
  localparam logic [3:0] RG_CHK_ERRS = 4'hA;
  localparam logic [3:0] RG_CHK_STAT = 4'hB;
  // Global register indices: pair switches at 0 and 1, boost table at 16..31.
  localparam int GX_TABLE_BIT = 4;
  // Equalizer control fields.
  localparam int EQ_MODE_LSB = 0;
  localparam int EQ_OVR      = 2;
  localparam int EQ_LIMIT    = 3;
  localparam int EQ_VGA      = 4;
  localparam int EQ_HIGAIN   = 5;
  localparam int EQ_DFE_OVR  = 6;
  localparam int EQ_DFE_ADPT = 7;
  localparam int EQ_IDX_LSB  = 8;
  localparam logic [11:0] EQ_CTRL_RST = 12'h020;
  // Clock recovery fields; standard preset 0 is the 25.78125 Gb/s rate.
  localparam int CDR_MANUAL  = 0;
  localparam int CDR_DIV_LSB = 1;
  localparam int CDR_STD_LSB = 3;
  localparam int CDR_RST_BIT = 7;
  // Transmit filter: three taps of five magnitude bits and a sign each.
  localparam int FIR_W      = 18;
  localparam int FIR_COMMIT = 31;
  // Pattern generator and checker fields.
  localparam int GEN_EN   = 0;
  localparam int GEN_TYPE = 1;
  localparam int GEN_INV  = 2;
  localparam int CHK_ON      = 0;
  localparam int CHK_FINITE  = 1;
  localparam int CHK_MIN_LSB = 2;
  localparam int CHK_HRS_LSB = 8;
  localparam int CHK_CLEAR   = 30;
  localparam int CHK_RESET   = 31;
  localparam int XP_SRC      = 2;
  localparam logic [13:0] MIN_PER_HOUR = 14'h003C;
  // Pattern polynomial taps, x^7+x^6+1 and x^31+x^28+1.
  localparam int P7_A = 6;
  localparam int P7_B = 5;
  localparam int P31_A = 30;
  localparam int P31_B = 27;
  localparam logic [30:0] LFSR_SEED = 31'h7FFFFFFF;
  localparam longint MINUTE_NS = 64'd60000000000;
  localparam longint CLK_NS    = 64'd4;
  localparam logic [33:0] MINUTE_CYCLES_DEF = 34'(MINUTE_NS / CLK_NS);
  typedef enum logic [1:0] {XP_DEFAULT, XP_FANOUT, XP_CROSS} xp_mode_t;
endpackage

// File: logic/retimer_channel_config.sv
// Register file, lane cross-point and pattern generator/checker of a four-lane retimer.
// Assumes a classic Wishbone master on REF_CLK and one received bit per lane per clock.
// What this block does
// - Two-by-two switch per pair 0-1 and 2-3.
// - Default mode: transmitter takes own receiver.
// - Fanout: chosen receiver drives both pair transmitters.
// - Lane crossing: transmitters take partner receiver.
// - Four adapt modes, per channel or all, readable.
// - Limiting bit makes last boost stage limit.
// - Gain enable switches variable gain stage on.
// - High gain equalizer mode, on after reset.
// - Sixteen writable boost table entries.
// - Five readable feedback taps, writable under override.
// - Per-channel enable for continuous tap adaptation.
// - Reset gives standard mode, 25.78125 Gb/s preset.
// - Transmit taps readable, applied on commit.
// - Generator: pattern, polarity, starts when enabled.
// - Checker runs forever or hours and minutes.
// - Clear zeroes counters; reset restores settings.
// - Turning checker off restores default settings.
// - Broadcast channel write reaches every channel.
`timescale 1ns/1ns
module retimer_channel_config
  import retimer_cfg_pkg::*;
#(
  parameter logic [33:0] MINUTE_CYCLES = MINUTE_CYCLES_DEF
) (
  input  wire logic              REF_CLK,
  input  wire logic              RESETN,
  input  wire logic [ADR_W-1:0]  ADR_I,
  input  wire logic [31:0]       DAT_I,
  input  wire logic [3:0]        SEL_I,
  input  wire logic              WE_I,
  input  wire logic              CYC_I,
  input  wire logic              STB_I,
  output logic [31:0]            DAT_O,
  output logic                   ACK_O,
  input  wire logic [3:0]        RX_DATA,
  output logic [3:0]             TX_DATA,
  output logic [3:0]             CDR_RESET,
  output logic [7:0]             ADAPT_MODE,
  output logic [31:0]            EQ_BOOST,
  output logic [3:0]             EQ_LIMIT,
  output logic [3:0]             VGA_EN,
  output logic [3:0]             HI_GAIN,
  output logic [3:0]             DFE_ADAPT_EN,
  output logic [3:0]             CDR_MANUAL,
  output logic [7:0]             CDR_DIV,
  output logic [71:0]            TX_FIR_TAPS
);
  typedef struct packed {
    logic                  ack;
    logic [31:0]           rdat;
    logic [3:0][11:0]      eq_ctrl;
    logic [3:0][7:0]       boost_man;
    logic [3:0][7:0]       boost_out;
    logic [3:0][29:0]      dfe;
    logic [3:0][6:0]       cdr;
    logic [3:0]            cdr_rst;
    logic [3:0][15:0]      rate0;
    logic [3:0][15:0]      rate1;
    logic [3:0][FIR_W-1:0] fir_stage;
    logic [3:0][FIR_W-1:0] fir_act;
    logic [3:0][2:0]       gen;
    logic [3:0][30:0]      lfsr;
    logic [3:0][15:0]      chk;
    logic [3:0][30:0]      chk_sr;
    logic [3:0][31:0]      bits;
    logic [3:0][31:0]      errs;
    logic [3:0][13:0]      remain;
    logic [3:0][33:0]      presc;
    logic [3:0]            done;
    logic [1:0][2:0]       xp;
    logic [15:0][7:0]      table_q;
    logic [3:0]            tx;
  } state_t;

  state_t s_q;
  state_t s_d;

  logic       req;
  logic       wr;
  logic       rd;
  logic       glob;
  logic       bc;
  logic [1:0] ch;
  logic [3:0] ri;
  logic [4:0] gi;

  assign req  = CYC_I && STB_I && !s_q.ack;
  assign wr   = req && WE_I;
  assign rd   = req && !WE_I;
  assign glob = ADR_I[ADR_GLOBAL];
  assign bc   = ADR_I[ADR_BCAST];
  assign ch   = ADR_I[ADR_CH_LSB +: 2];
  assign ri   = ADR_I[ADR_RG_LSB +: 4];
  assign gi   = ADR_I[ADR_RG_LSB +: 5];

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d, input logic [3:0] sel);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (sel[i]) begin
        r[8*i +: 8] = d[8*i +: 8];
      end
    end
    return r;
  endfunction

  always_comb begin
    logic [31:0] m;
    logic        hit;
    logic        fb;
    logic        exp_b;
    logic [1:0]  cb;
    logic [1:0]  src;
    m     = '0;
    hit   = 1'b0;
    fb    = 1'b0;
    exp_b = 1'b0;
    cb    = '0;
    src   = '0;
    s_d = s_q;
    s_d.ack     = req;
    s_d.rdat    = '0;
    s_d.cdr_rst = '0;
    for (int c = 0; c < NUM_CH; c++) begin
      cb = 2'(c);
      fb = s_q.gen[c][GEN_TYPE] ? s_q.lfsr[c][P31_A] ^ s_q.lfsr[c][P31_B]
                                : s_q.lfsr[c][P7_A] ^ s_q.lfsr[c][P7_B];
      s_d.lfsr[c] = {s_q.lfsr[c][29:0], fb};
      exp_b = s_q.gen[c][GEN_TYPE] ? s_q.chk_sr[c][P31_A] ^ s_q.chk_sr[c][P31_B]
                                   : s_q.chk_sr[c][P7_A] ^ s_q.chk_sr[c][P7_B];
      s_d.chk_sr[c] = {s_q.chk_sr[c][29:0], RX_DATA[c]};
      case (s_q.xp[c/2][1:0])
        XP_FANOUT: src = {cb[1], s_q.xp[c/2][XP_SRC]};
        XP_CROSS:  src = cb ^ 2'h1;
        default:   src = cb;
      endcase
      s_d.tx[c] = s_q.gen[c][GEN_EN] ? fb ^ s_q.gen[c][GEN_INV] : RX_DATA[src];
      // The table index is only a stand-in for the adapted boost until the analog loop reports one.
      s_d.boost_out[c] = s_q.eq_ctrl[c][EQ_OVR] ? s_q.boost_man[c]
                                                : s_q.table_q[s_q.eq_ctrl[c][EQ_IDX_LSB +: 4]];
      if (s_q.chk[c][CHK_ON] && !s_q.done[c]) begin
        s_d.bits[c] = s_q.bits[c] + 32'h1;
        s_d.errs[c] = s_q.errs[c] + {31'h0, RX_DATA[c] ^ exp_b};
        if (s_q.chk[c][CHK_FINITE]) begin
          if (s_q.remain[c] == 14'h0) begin
            s_d.done[c] = 1'b1;
          end else if (s_q.presc[c] == MINUTE_CYCLES - 34'h1) begin
            s_d.presc[c]  = '0;
            s_d.remain[c] = s_q.remain[c] - 14'h1;
            s_d.done[c]   = (s_q.remain[c] == 14'h1);
          end else begin
            s_d.presc[c] = s_q.presc[c] + 34'h1;
          end
        end
      end
      hit = wr && !glob && (bc || ch == cb);
      if (hit) begin
        case (ri)
          RG_EQ_CTRL: s_d.eq_ctrl[c] = 12'(merge({20'h0, s_q.eq_ctrl[c]}, DAT_I, SEL_I));
          RG_BOOST:   s_d.boost_man[c] = 8'(merge({24'h0, s_q.boost_man[c]}, DAT_I, SEL_I));
          RG_DFE: begin
            if (s_q.eq_ctrl[c][EQ_DFE_OVR]) begin
              s_d.dfe[c] = 30'(merge({2'h0, s_q.dfe[c]}, DAT_I, SEL_I));
            end
          end
          RG_CDR: begin
            m = merge({25'h0, s_q.cdr[c]}, DAT_I, SEL_I);
            s_d.cdr[c]     = m[6:0];
            s_d.cdr_rst[c] = m[CDR_RST_BIT];
          end
          RG_RATE0: s_d.rate0[c] = 16'(merge({16'h0, s_q.rate0[c]}, DAT_I, SEL_I));
          RG_RATE1: s_d.rate1[c] = 16'(merge({16'h0, s_q.rate1[c]}, DAT_I, SEL_I));
          RG_TXFIR: begin
            m = merge({14'h0, s_q.fir_stage[c]}, DAT_I, SEL_I);
            s_d.fir_stage[c] = m[FIR_W-1:0];
            if (m[FIR_COMMIT]) begin
              s_d.fir_act[c] = m[FIR_W-1:0];
            end
          end
          RG_GEN: s_d.gen[c] = 3'(merge({29'h0, s_q.gen[c]}, DAT_I, SEL_I));
          RG_CHK: begin
            m = merge({16'h0, s_q.chk[c]}, DAT_I, SEL_I);
            if (!m[CHK_ON]) begin
              s_d.chk[c]  = '0;
              s_d.done[c] = 1'b0;
            end else if (m[CHK_RESET]) begin
              s_d.chk[c]  = 16'h0001;
              s_d.done[c] = 1'b0;
            end else begin
              s_d.chk[c] = m[15:0];
              if (!s_q.chk[c][CHK_ON]) begin
                s_d.remain[c] = {6'h0, m[CHK_HRS_LSB +: 8]} * MIN_PER_HOUR + {8'h0, m[CHK_MIN_LSB +: 6]};
                s_d.presc[c]  = '0;
                s_d.bits[c]   = '0;
                s_d.errs[c]   = '0;
                s_d.done[c]   = 1'b0;
              end
            end
            if (m[CHK_CLEAR]) begin
              s_d.bits[c] = '0;
              s_d.errs[c] = '0;
            end
          end
          default: ;
        endcase
      end
      if (rd && !glob && ch == cb) begin
        case (ri)
          RG_EQ_CTRL:  s_d.rdat = {20'h0, s_q.eq_ctrl[c]};
          RG_BOOST:    s_d.rdat = {24'h0, s_q.boost_out[c]};
          RG_DFE:      s_d.rdat = {2'h0, s_q.dfe[c]};
          RG_CDR:      s_d.rdat = {25'h0, s_q.cdr[c]};
          RG_RATE0:    s_d.rdat = {16'h0, s_q.rate0[c]};
          RG_RATE1:    s_d.rdat = {16'h0, s_q.rate1[c]};
          RG_TXFIR:    s_d.rdat = {14'h0, s_q.fir_act[c]};
          RG_GEN:      s_d.rdat = {29'h0, s_q.gen[c]};
          RG_CHK:      s_d.rdat = {16'h0, s_q.chk[c]};
          RG_CHK_BITS: s_d.rdat = s_q.bits[c];
          RG_CHK_ERRS: s_d.rdat = s_q.errs[c];
          RG_CHK_STAT: s_d.rdat = {30'h0, s_q.done[c], s_q.chk[c][CHK_ON] && !s_q.done[c]};
          default:     s_d.rdat = '0;
        endcase
      end
    end
    if (glob && gi[GX_TABLE_BIT]) begin
      if (wr) begin
        s_d.table_q[gi[3:0]] = 8'(merge({24'h0, s_q.table_q[gi[3:0]]}, DAT_I, SEL_I));
      end
      if (rd) begin
        s_d.rdat = {24'h0, s_q.table_q[gi[3:0]]};
      end
    end else if (glob && gi[4:1] == 4'h0) begin
      if (wr) begin
        s_d.xp[gi[0]] = 3'(merge({29'h0, s_q.xp[gi[0]]}, DAT_I, SEL_I));
      end
      if (rd) begin
        s_d.rdat = {29'h0, s_q.xp[gi[0]]};
      end
    end
  end

  always_ff @(posedge REF_CLK) begin
    if (!RESETN) begin
      s_q         <= '0;
      s_q.eq_ctrl <= {NUM_CH{EQ_CTRL_RST}};
      s_q.lfsr    <= {NUM_CH{LFSR_SEED}};
    end else begin
      s_q <= s_d;
    end
  end

  assign ACK_O       = s_q.ack;
  assign DAT_O       = s_q.rdat;
  assign TX_DATA     = s_q.tx;
  assign CDR_RESET   = s_q.cdr_rst;
  assign EQ_BOOST    = s_q.boost_out;
  assign TX_FIR_TAPS = s_q.fir_act;
  for (genvar g = 0; g < NUM_CH; g++) begin : g_ch
    assign ADAPT_MODE[2*g +: 2] = s_q.eq_ctrl[g][EQ_MODE_LSB +: 2];
    // The port names hide the package field positions of the same name, so these two are scoped.
    assign EQ_LIMIT[g]          = s_q.eq_ctrl[g][retimer_cfg_pkg::EQ_LIMIT];
    assign VGA_EN[g]            = s_q.eq_ctrl[g][EQ_VGA];
    assign HI_GAIN[g]           = s_q.eq_ctrl[g][EQ_HIGAIN];
    assign DFE_ADAPT_EN[g]      = s_q.eq_ctrl[g][EQ_DFE_ADPT];
    assign CDR_MANUAL[g]        = s_q.cdr[g][retimer_cfg_pkg::CDR_MANUAL];
    assign CDR_DIV[2*g +: 2]    = s_q.cdr[g][CDR_DIV_LSB +: 2];
  end

  default clocking cb_main @(posedge REF_CLK); endclocking
  default disable iff (!RESETN);

  AST_DEFAULT_ROUTE: assert property (
    (s_q.xp[0][1:0] == XP_DEFAULT && !s_q.gen[0][GEN_EN]) |=> TX_DATA[0] == $past(RX_DATA[0], 1))
    else $error("Default route lost lane 0.");
  AST_FANOUT: assert property (
    (s_q.xp[0] == {1'b0, XP_FANOUT} && s_q.gen[1:0] == '0) |=> TX_DATA[1:0] == {2{$past(RX_DATA[0])}})
    else $error("Fanout did not copy lane 0.");
  AST_CROSS: assert property (
    (s_q.xp[0][1:0] == XP_CROSS && s_q.gen[1:0] == '0) |=> TX_DATA[1:0] == {$past(RX_DATA[0]), $past(RX_DATA[1])})
    else $error("Lane crossing failed.");
  AST_PAIR_SPLIT: assert property (
    (s_q.xp[1][1:0] == XP_CROSS && !s_q.gen[3][GEN_EN]) |=> TX_DATA[3] == $past(RX_DATA[2]))
    else $error("Second pair did not cross.");
  AST_BCAST: assert property (
    (wr && !glob && bc && ri == RG_EQ_CTRL && SEL_I[0]) |=> ADAPT_MODE == {4{$past(DAT_I[1:0])}})
    else $error("Broadcast did not reach all channels.");
  AST_SELECT: assert property (
    (wr && !glob && !bc && ch == 2'h0) |=> $stable(s_q.eq_ctrl[1]) && $stable(s_q.cdr[1]))
    else $error("Write touched an unselected channel.");
  AST_RESET_STATE: assert property (
    $past(!RESETN) |-> (CDR_MANUAL == 4'h0 && s_q.cdr[0][CDR_STD_LSB +: 4] == 4'h0 && HI_GAIN == 4'hF))
    else $error("Reset state wrong.");
  AST_STOP_COUNT: assert property (
    (s_q.done[0] && !wr) |=> $stable(s_q.bits[0]) && $stable(s_q.errs[0]))
    else $error("Checker kept counting after expiry.");
  AST_TAP_COMMIT: assert property (
    (wr && !glob && ri == RG_TXFIR && !DAT_I[FIR_COMMIT]) |=> $stable(TX_FIR_TAPS))
    else $error("Taps changed without commit.");
  AST_OFF_IDLE: assert property (
    !s_q.chk[0][CHK_ON] |=> $stable(s_q.bits[0]) || s_q.bits[0] == 32'h0)
    else $error("Checker counted while off.");
  COV_FANOUT: cover property (s_q.xp[1][1:0] == XP_FANOUT);
  COV_EXPIRE: cover property ($rose(s_q.done[0]));
  COV_BCAST: cover property (wr && bc && !glob);
endmodule

// File: verification/lane_partner.sv
// Link partner on the four serial lanes of the retimer.
// Assumes one bit per lane per clock; loop_back returns each transmitted bit one clock later.
`timescale 1ns/1ns
module lane_partner (
  input  wire logic       clk,
  input  wire logic       resetn,
  input  wire logic       loop_back,
  input  wire logic [3:0] tx_data,
  output logic [3:0]      rx_data,
  output logic [3:0]      rx_prev
);
  // An odd stride walks all sixteen lane patterns, so every routing case is seen within 16 clocks.
  always_ff @(posedge clk) begin
    if (!resetn) begin
      rx_data <= 4'h5;
    end else if (loop_back) begin
      rx_data <= tx_data;
    end else begin
      rx_data <= rx_data + 4'h3;
    end
    rx_prev <= rx_data;
  end
endmodule

// File: verification/retimer_channel_config_bench.sv
// Self-checking bench for the retimer configuration block.
// Assumes the package constants and a Wishbone slave that acks one clock after taking a request.
`timescale 1ns/1ns
module retimer_channel_config_bench
  import retimer_cfg_pkg::*;
;
  logic        clk = 1'b0;
  logic        resetn;
  logic [9:0]  adr;
  logic [31:0] dat_w, dat_r, q;
  logic [3:0]  sel, rx, prev, tx, cdr_reset, eq_limit, vga_en, hi_gain, dfe_adapt_en, cdr_manual;
  logic        we, cyc, stb, ack, loop_back;
  logic [7:0]  adapt_mode, cdr_div;
  logic [31:0] eq_boost;
  logic [71:0] tx_fir_taps;
  logic [3:0]  rst_seen = 4'h0;
  logic [7:0]  rst_cycles = 8'h00;
  int          mismatches = 0;
  int          checked = 0;

  always #2 clk = ~clk;

  retimer_channel_config #(.MINUTE_CYCLES(34'h14)) dut (
    .REF_CLK(clk), .RESETN(resetn), .ADR_I(adr), .DAT_I(dat_w), .SEL_I(sel), .WE_I(we),
    .CYC_I(cyc), .STB_I(stb), .DAT_O(dat_r), .ACK_O(ack), .RX_DATA(rx), .TX_DATA(tx),
    .CDR_RESET(cdr_reset), .ADAPT_MODE(adapt_mode), .EQ_BOOST(eq_boost), .EQ_LIMIT(eq_limit),
    .VGA_EN(vga_en), .HI_GAIN(hi_gain), .DFE_ADAPT_EN(dfe_adapt_en), .CDR_MANUAL(cdr_manual),
    .CDR_DIV(cdr_div), .TX_FIR_TAPS(tx_fir_taps));

  lane_partner partner (.clk(clk), .resetn(resetn), .loop_back(loop_back), .tx_data(tx),
    .rx_data(rx), .rx_prev(prev));

  always @(posedge clk) begin
    if (resetn) begin
      rst_seen <= rst_seen | cdr_reset;
      rst_cycles <= rst_cycles + 8'(cdr_reset != 4'h0);
    end
  end

  function automatic logic [9:0] ca(input logic [1:0] c, input logic [3:0] r, input logic b);
    ca = {1'b0, b, c, r, 2'b00};
  endfunction

  function automatic logic [9:0] ga(input logic [4:0] i);
    ga = {3'b100, i, 2'b00};
  endfunction

  function automatic logic [1:0] route(input logic [1:0] m, input logic s, input logic [1:0] r);
    case (m)
      2'h1: route = s ? {r[1], r[1]} : {r[0], r[0]};
      2'h2: route = {r[0], r[1]};
      default: route = r;
    endcase
  endfunction

  task automatic finish_test();
    $display("checks %0d, mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  task automatic check(input logic [71:0] got, input logic [71:0] exp, input string what);
    checked++;
    if (got !== exp) begin
      mismatches++;
      $display("unexpected at %0t: %s got %0h expected %0h", $time, what, got, exp);
    end
  endtask

  // The request is held until ack is sampled high, so any slave latency up to 50 clocks is tolerated here.
  task automatic wb(input logic w, input logic [9:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    dat_w <= d;
    do begin
      @(posedge clk);
      n++;
    end while (ack !== 1'b1 && n < 50);
    if (ack !== 1'b1) begin
      mismatches++;
      $display("unexpected at %0t: no bus answer", $time);
      finish_test();
    end else begin
      q = dat_r;
      cyc <= 1'b0;
      stb <= 1'b0;
    end
  endtask

  task automatic wr(input logic [9:0] a, input logic [31:0] d);
    wb(1'b1, a, d);
  endtask

  task automatic rd(input logic [9:0] a, input logic [31:0] e);
    wb(1'b0, a, 32'h0);
    check(q, e, "read");
  endtask

  task automatic settle();
    repeat (3) @(posedge clk);
  endtask

  task automatic xp(input logic [1:0] m0, input logic [1:0] m1, input logic s);
    wr(ga(5'h00), {29'h0, s, m0});
    wr(ga(5'h01), {29'h0, s, m1});
    settle();
    repeat (20) begin
      @(posedge clk);
      check(tx, {route(m1, s, prev[3:2]), route(m0, s, prev[1:0])}, "lanes");
    end
  endtask

  initial begin
    int ones;
    logic [31:0] b;
    resetn = 1'b0;
    {cyc, stb, we, loop_back} = 4'h0;
    adr = 10'h000;
    dat_w = 32'h0;
    sel = 4'hF;
    repeat (2) @(posedge clk);
    resetn <= 1'b1;
    rd(ca(2'h0, RG_EQ_CTRL, 1'b0), 32'h20);
    rd(ca(2'h2, RG_CDR, 1'b0), 32'h0);
    check({hi_gain, cdr_manual}, 8'hF0, "reset levels");
    wr(ga(5'h07), 32'hFFFFFFFF);
    rd(ga(5'h07), 32'h0);
    $display("test reset done");
    for (int m = 0; m < 4; m++) begin
      wr(ca(2'h1, RG_EQ_CTRL, 1'b0), 32'h20 | m);
      rd(ca(2'h1, RG_EQ_CTRL, 1'b0), 32'h20 | m);
      settle();
      check(adapt_mode, 8'(m << 2), "adapt one");
    end
    wr(ca(2'h0, RG_EQ_CTRL, 1'b1), 32'h22);
    settle();
    check(adapt_mode, 8'hAA, "adapt all");
    wr(ca(2'h2, RG_EQ_CTRL, 1'b0), 32'h9A);
    settle();
    check({eq_limit, vga_en, dfe_adapt_en, hi_gain}, 16'h444B, "eq bits");
    $display("test equalizer done");
    wr(ga(5'h15), 32'hA5);
    rd(ga(5'h15), 32'hA5);
    wr(ca(2'h3, RG_EQ_CTRL, 1'b0), 32'h520);
    settle();
    check(eq_boost[31:24], 8'hA5, "table boost");
    wr(ca(2'h3, RG_EQ_CTRL, 1'b0), 32'h524);
    wr(ca(2'h3, RG_BOOST, 1'b0), 32'h3C);
    wr(ca(2'h3, RG_CDR, 1'b0), 32'h80);
    settle();
    check({eq_boost[31:24], rst_seen, rst_cycles}, 20'h3C801, "manual boost");
    wr(ca(2'h1, RG_DFE, 1'b0), 32'h15555555);
    rd(ca(2'h1, RG_DFE, 1'b0), 32'h0);
    wr(ca(2'h1, RG_EQ_CTRL, 1'b0), 32'h60);
    wr(ca(2'h1, RG_DFE, 1'b0), 32'h15555555);
    sel <= 4'h3;
    wr(ca(2'h1, RG_DFE, 1'b0), 32'h3FFFFFFF);
    sel <= 4'hF;
    rd(ca(2'h1, RG_DFE, 1'b0), 32'h1555FFFF);
    $display("test boost and taps done");
    wr(ca(2'h3, RG_CDR, 1'b0), 32'h03);
    wr(ca(2'h3, RG_RATE0, 1'b0), 32'h1234);
    wr(ca(2'h3, RG_RATE1, 1'b0), 32'hABCD);
    wr(ca(2'h3, RG_CDR, 1'b0), 32'h83);
    settle();
    check({cdr_manual, cdr_div, rst_cycles}, 20'h84002, "manual rate");
    rd(ca(2'h3, RG_CDR, 1'b0), 32'h03);
    rd(ca(2'h3, RG_RATE1, 1'b0), 32'hABCD);
    wr(ca(2'h0, RG_TXFIR, 1'b0), 32'h2ABCD);
    rd(ca(2'h0, RG_TXFIR, 1'b0), 32'h0);
    wr(ca(2'h0, RG_TXFIR, 1'b0), 32'h8002ABCD);
    settle();
    check(tx_fir_taps[17:0], 18'h2ABCD, "fir taps");
    $display("test rate and filter done");
    xp(2'h0, 2'h0, 1'b0);
    xp(2'h1, 2'h1, 1'b0);
    xp(2'h1, 2'h1, 1'b1);
    xp(2'h2, 2'h0, 1'b0);
    xp(2'h3, 2'h2, 1'b0);
    $display("test cross-point done");
    loop_back <= 1'b1;
    wr(ca(2'h0, RG_GEN, 1'b0), 32'h1);
    settle();
    ones = 0;
    repeat (16) begin
      @(posedge clk);
      ones += int'(tx[0]);
    end
    check(8'(ones > 0 && ones < 16), 8'h1, "pattern moves");
    wr(ca(2'h0, RG_CHK, 1'b0), 32'h7);
    repeat (40) @(posedge clk);
    rd(ca(2'h0, RG_CHK_STAT, 1'b0), 32'h2);
    wb(1'b0, ca(2'h0, RG_CHK_BITS, 1'b0), 32'h0);
    b = q;
    check(b, 32'h14, "bits in one minute");
    repeat (10) @(posedge clk);
    rd(ca(2'h0, RG_CHK_BITS, 1'b0), b);
    check(8'(b != 32'h0), 8'h1, "bits counted");
    wr(ca(2'h0, RG_CHK, 1'b0), 32'h40000007);
    rd(ca(2'h0, RG_CHK_BITS, 1'b0), 32'h0);
    wr(ca(2'h0, RG_CHK, 1'b0), 32'h0);
    rd(ca(2'h0, RG_CHK, 1'b0), 32'h0);
    wr(ca(2'h0, RG_CHK, 1'b0), 32'h1);
    repeat (100) @(posedge clk);
    rd(ca(2'h0, RG_CHK_STAT, 1'b0), 32'h1);
    rd(ca(2'h0, RG_CHK_ERRS, 1'b0), 32'h0);
    wr(ca(2'h0, RG_CHK, 1'b0), 32'h80000007);
    rd(ca(2'h0, RG_CHK, 1'b0), 32'h1);
    wr(ca(2'h0, RG_GEN, 1'b0), 32'h3);
    repeat (40) @(posedge clk);
    wr(ca(2'h0, RG_CHK, 1'b0), 32'h40000001);
    repeat (20) @(posedge clk);
    rd(ca(2'h0, RG_CHK_ERRS, 1'b0), 32'h0);
    wr(ca(2'h0, RG_GEN, 1'b0), 32'h7);
    repeat (40) @(posedge clk);
    wr(ca(2'h0, RG_CHK, 1'b0), 32'h40000001);
    repeat (20) @(posedge clk);
    wb(1'b0, ca(2'h0, RG_CHK_ERRS, 1'b0), 32'h0);
    check(8'(q != 32'h0), 8'h1, "inverted pattern");
    $display("test pattern done");
    finish_test();
  end
endmodule
